// File: src/asr_pkg.sv
package asr_pkg;

   // ************************************************************
   // register indices on the plain register port
   // ************************************************************
   localparam logic [2:0] ADDR_RCV_STAT  = 3'h0;
   localparam logic [2:0] ADDR_RCV_DATA  = 3'h1;
   localparam logic [2:0] ADDR_XMT_STAT  = 3'h2;
   localparam logic [2:0] ADDR_BAUD_CTL  = 3'h3;
   localparam logic [2:0] ADDR_DIV_LO    = 3'h4;
   localparam logic [2:0] ADDR_DIV_HI    = 3'h5;
   localparam logic [2:0] ADDR_INT_CTL   = 3'h6;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int RS_SERIAL_PORT_ENABLE   = 7;
   localparam int RS_RX9    = 6;
   localparam int RS_SREN   = 5;
   localparam int RS_CONTINUOUS_RECEIVE_ENABLE   = 4;
   localparam int RS_ADDRESS_DETECT_ENABLE  = 3;
   localparam int TX_SYNC   = 4;
   localparam int TX_HRATE  = 2;
   localparam int BC_IDLE   = 6;
   localparam int BC_WIDE   = 3;
   localparam int IC_RECEIVE_INTERRUPT_ENABLE   = 0;
   localparam int IC_PERIPHERAL_INTERRUPT_ENABLE   = 1;
   localparam int IC_GIE    = 2;
   localparam int IC_RDY    = 3;

   // ************************************************************
   // reset values, masks and timing counts
   // ************************************************************
   localparam logic [7:0] RESET_BYTE    = 8'h00;
   localparam logic [7:0] BAUD_WR_MASK  = 8'h1b;
   localparam logic [2:0] INT_ALL_EN    = 3'h7;
   localparam logic [3:0] DECIDE_TICK   = 4'h9;
   localparam logic [3:0] LAST_BIT8     = 4'h7;
   localparam logic [3:0] LAST_BIT9     = 4'h8;
   localparam logic [1:0] FIFO_FULL     = 2'h2;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_START = 2'b01,
      ST_DATA  = 2'b10,
      ST_STOP  = 2'b11
   } asr_rx_e;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [2:0] addr;
      logic [7:0] wdata;
   } asr_bus_req_s;

   typedef struct packed {
      logic rx_oe;
      logic tx_out;
      logic tx_oe;
   } asr_pins_s;

   typedef struct packed {
      logic       framing_error_status;
      logic [8:0] data;
   } asr_entry_s;

   typedef struct packed {
      logic                  sync1;
      logic                  sync2;
      logic                  prev;
      asr_rx_e               st;
      logic [3:0]            tick_cnt;
      logic [3:0]            bit_cnt;
      logic [1:0]            samp;
      logic [8:0]            shreg;
      asr_entry_s [1:0]      fifo;
      logic                  wr_ptr;
      logic                  rd_ptr;
      logic [1:0]            cnt;
      logic                  serial_port_enable;
      logic                  rx9;
      logic                  sren;
      logic                  continuous_receive_enable;
      logic                  address_detect_enable;
      logic                  overrun_flag;
      logic [7:0]            transmit_status_control;
      logic [7:0]            baud_control;
      logic [7:0]            div_lo;
      logic [7:0]            div_hi;
      logic [2:0]            intctl;
      logic [7:0]            rdata;
      logic                  rx_ready;
      logic                  irq;
      asr_pins_s             pins;
   } asr_state_s;

endpackage

// File: src/asr_receiver.sv
// Operation
// RULE1: line sampled at sixteen ticks per bit; shift register moves once per bit.
// RULE2: finished 8 or 9 bit character goes at once into a two-entry FIFO.
// RULE3: reception runs only with continuous enable, async mode and port enable.
// RULE4: port enable forces receive pin input and transmit/clock pin output.
// RULE5: start bit high at half-bit check is dropped silently; edge search resumes.
// RULE6: each data bit decided by majority at its centre, one bit apart.
// RULE7: stop position sampled one bit later; low sets that character's frame error.
// RULE8: after stop sample the character is written and the ready flag rises.
// RULE9: reading receive data returns and removes the oldest FIFO character.
// RULE10: ready flag equals enabled and unread character present; software cannot touch.
// RULE11: interrupt only when all three enables and the ready flag are set.
// RULE12: frame error stored per entry; status shows the top unread entry.
// RULE13: frame error read-only, cleared by port disable only, never interrupts.
// RULE14: a framing error does not stop reception of following characters.
// RULE15: third complete character with FIFO full sets overrun and blocks reception.
// RULE16: overrun cleared only by clearing continuous enable or port enable.
// RULE17: nine-bit mode shifts nine bits; ninth bit shown in a status bit.
// RULE18: software reads status before data, since data read advances the FIFO.
// RULE19: address mode with nine bits stores only characters with ninth bit set.
// RULE20: software clears address mode before next stop bit, sets it after message.
// RULE21: software sets rate, port, interrupts, nine bits, address, then reception.
// RULE22: software switches a shared analog receive pin to digital first.
// RULE23: first data bit received lands in bit zero.
// RULE24: sample tick is a one-cycle pulse; receive pin passes two flip-flops.
`timescale 1ns/1ns
module asr_receiver
   import asr_pkg::*;
(
   // clock and reset
   input  wire logic          i_ref_clk,
   input  wire logic          i_reset,
   // sixteen-times bit rate tick from the baud generator
   input  wire logic          i_sample_tick,
   // receive pin level and port pin controls
   input  wire logic          i_rx_pin,
   input  wire logic          i_rx_dir_in,
   input  wire logic          i_tx_dir_in,
   input  wire logic          i_tx_latch,
   input  wire logic          i_tx_serial,
   // register port
   input  wire asr_bus_req_s  i_bus,
   output logic [7:0]         o_rdata,
   // baud generator settings
   output logic [15:0]        o_baud_div,
   output logic               o_high_rate,
   output logic               o_wide_div,
   // status and interrupt request
   output logic               o_rx_ready,
   output logic               o_irq,
   // pin drivers
   output asr_pins_s          o_pins
);

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic maj3(input logic [2:0] s);
      maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction

   function automatic logic [7:0] read_mux(input asr_state_s s,
                                            input logic [2:0] a,
                                            input asr_entry_s top);
      logic [7:0] v;
      v = RESET_BYTE;
      if (a == ADDR_RCV_STAT)
         v = {s.serial_port_enable, s.rx9, s.sren, s.continuous_receive_enable, s.address_detect_enable,
              top.framing_error_status, s.overrun_flag, top.data[8]};
      else if (a == ADDR_RCV_DATA)
         v = top.data[7:0];
      else if (a == ADDR_XMT_STAT)
         v = s.transmit_status_control;
      else if (a == ADDR_BAUD_CTL)
      begin
         v = s.baud_control;
         v[BC_IDLE] = (s.st == ST_IDLE);
      end
      else if (a == ADDR_DIV_LO)
         v = s.div_lo;
      else if (a == ADDR_DIV_HI)
         v = s.div_hi;
      else if (a == ADDR_INT_CTL)
      begin
         v[2:0] = s.intctl;
         v[IC_RDY] = s.rx_ready;
      end
      return v;
   endfunction

   asr_state_s q;
   asr_state_s d;

   // ************************************************************
   // shared decode
   // ************************************************************
   logic       rx_act;
   logic       decide;
   logic       maj;
   logic       done;
   logic       accept;
   logic       addr_drop;
   logic       pop;
   logic       push;
   logic       full;
   logic [8:0] char9;
   asr_entry_s top;

   assign rx_act = q.serial_port_enable & q.continuous_receive_enable & ~q.transmit_status_control[TX_SYNC]; // [RULE3]
   assign decide = i_sample_tick && (q.tick_cnt == DECIDE_TICK); // [RULE1]
   // three samples around the bit centre, the newest still in the sync
   assign maj    = maj3({q.samp, q.sync2}); // [RULE6]
   // a disable in the stop cycle drops the character, so overrun stays clear
   assign done   = decide && (q.st == ST_STOP) && rx_act;
   assign top    = q.fifo[q.rd_ptr];
   // 8-bit characters sit one place high in the shifter
   assign char9  = q.rx9 ? q.shreg : {1'b0, q.shreg[8:1]}; // [RULE23]
   assign addr_drop = q.address_detect_enable & q.rx9 & ~char9[8]; // [RULE19]
   assign accept = done & ~q.overrun_flag & ~addr_drop; // [RULE15]
   assign pop    = i_bus.rd && (i_bus.addr == ADDR_RCV_DATA)
                   && (q.cnt != 2'h0); // [RULE9]
   // a read in the same cycle frees a slot for the new character
   assign full   = (q.cnt == FIFO_FULL) && !pop;
   assign push   = accept && !full; // [RULE8]

   // ************************************************************
   // next state
   // ************************************************************
   always_comb
   begin
      d = q;
      d.sync1 = i_rx_pin; // [RULE24]
      d.sync2 = q.sync1;
      d.prev  = q.sync2;
      if (i_sample_tick)
         d.samp = {q.samp[0], q.sync2};
      if (q.st != ST_IDLE && i_sample_tick)
         d.tick_cnt = q.tick_cnt + 4'h1; // [RULE1]

      case (q.st)
         ST_IDLE:
         begin
            if (rx_act && q.prev && !q.sync2)
            begin
               d.st       = ST_START;
               d.tick_cnt = 4'h0;
            end
         end
         ST_START:
         begin
            if (decide)
            begin
               if (maj)
                  d.st = ST_IDLE; // [RULE5]
               else
               begin
                  d.st      = ST_DATA;
                  d.bit_cnt = 4'h0;
               end
            end
         end
         ST_DATA:
         begin
            if (decide)
            begin
               d.shreg   = {maj, q.shreg[8:1]}; // [RULE6] [RULE23]
               d.bit_cnt = q.bit_cnt + 4'h1;
               if (q.bit_cnt == (q.rx9 ? LAST_BIT9 : LAST_BIT8))
                  d.st = ST_STOP; // [RULE17]
            end
         end
         ST_STOP:
         begin
            // back to idle whatever the stop level was
            if (decide)
               d.st = ST_IDLE; // [RULE14]
         end
         default:
            d.st = ST_IDLE;
      endcase
      if (!rx_act)
         d.st = ST_IDLE; // [RULE3]

      // fifo write and read
      if (push)
      begin
         d.fifo[q.wr_ptr].data = char9; // [RULE2]
         d.fifo[q.wr_ptr].framing_error_status = ~maj; // [RULE7] [RULE12]
         d.wr_ptr = ~q.wr_ptr;
      end
      if (pop)
         d.rd_ptr = ~q.rd_ptr; // [RULE9]
      d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};

      if (accept && full)
         d.overrun_flag = 1'b1; // [RULE15]

      // register writes
      if (i_bus.wr)
      begin
         if (i_bus.addr == ADDR_RCV_STAT)
         begin
            d.serial_port_enable  = i_bus.wdata[RS_SERIAL_PORT_ENABLE];
            d.rx9   = i_bus.wdata[RS_RX9];
            d.sren  = i_bus.wdata[RS_SREN];
            d.continuous_receive_enable  = i_bus.wdata[RS_CONTINUOUS_RECEIVE_ENABLE];
            d.address_detect_enable = i_bus.wdata[RS_ADDRESS_DETECT_ENABLE];
         end
         else if (i_bus.addr == ADDR_XMT_STAT)
            d.transmit_status_control = i_bus.wdata;
         else if (i_bus.addr == ADDR_BAUD_CTL)
            d.baud_control = i_bus.wdata & BAUD_WR_MASK;
         else if (i_bus.addr == ADDR_DIV_LO)
            d.div_lo = i_bus.wdata;
         else if (i_bus.addr == ADDR_DIV_HI)
            d.div_hi = i_bus.wdata;
         else if (i_bus.addr == ADDR_INT_CTL)
            d.intctl = i_bus.wdata[2:0];
      end

      // a disable is a level, so it keeps the flag down while held
      if (!q.continuous_receive_enable || !q.serial_port_enable)
         d.overrun_flag = 1'b0; // [RULE16]
      // port disable resets the receive path, frame errors included
      if (!q.serial_port_enable)
      begin
         d.fifo   = '0; // [RULE13]
         d.wr_ptr = 1'b0;
         d.rd_ptr = 1'b0;
         d.cnt    = 2'h0;
      end

      d.rdata = i_bus.rd ? read_mux(q, i_bus.addr, top) : RESET_BYTE;
      d.rx_ready = rx_act && (q.cnt != 2'h0); // [RULE10]
      // the frame error bit never feeds the request
      d.irq = rx_act && (q.cnt != 2'h0)
              && (q.intctl == INT_ALL_EN); // [RULE11] [RULE13]

      d.pins.rx_oe  = q.serial_port_enable ? 1'b0 : ~i_rx_dir_in; // [RULE4]
      d.pins.tx_oe  = q.serial_port_enable ? 1'b1 : ~i_tx_dir_in; // [RULE4]
      d.pins.tx_out = q.serial_port_enable ? i_tx_serial : i_tx_latch;
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
         q <= '0;
      else
         q <= d;
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign o_rdata     = q.rdata;
   assign o_baud_div  = {q.div_hi, q.div_lo};
   assign o_high_rate = q.transmit_status_control[TX_HRATE];
   assign o_wide_div  = q.baud_control[BC_WIDE];
   assign o_rx_ready  = q.rx_ready;
   assign o_irq       = q.irq;
   assign o_pins      = q.pins;

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_reset);

   a_fifo_depth_bound: assert property ( // [RULE2]
      q.cnt <= FIFO_FULL)
      else $error("fifo count above two");

   a_overrun_flag_clear_by_continuous_receive_enable: assert property ( // [RULE16]
      (!q.continuous_receive_enable || !q.serial_port_enable) |=> !q.overrun_flag)
      else $error("overrun flag survived a disable");

   a_overrun_flag_set_full: assert property ( // [RULE15]
      (accept && full) |=> q.overrun_flag && $stable(q.cnt))
      else $error("third character did not raise overrun");

   a_ready_tracks_fifo: assert property ( // [RULE10]
      q.rx_ready == $past(rx_act && (q.cnt != 2'h0)))
      else $error("ready flag does not follow fifo");

   a_irq_needs_enables: assert property ( // [RULE11]
      q.irq |-> ($past(q.intctl) == INT_ALL_EN) && q.rx_ready)
      else $error("interrupt without all enables");

   a_start_abort_quiet: assert property ( // [RULE5]
      (q.st == ST_START && decide && maj)
      |=> q.st == ST_IDLE && $stable(q.cnt) && $stable(q.overrun_flag))
      else $error("false start not abandoned silently");

   a_addr_drop_char: assert property ( // [RULE19]
      (done && addr_drop && !pop) |=> $stable(q.cnt) ##1 $stable(q.overrun_flag))
      else $error("address mode stored a data character");

   a_pop_advances: assert property ( // [RULE9]
      (pop && !push) |=> (q.cnt == $past(q.cnt) - 2'h1)
                          && (q.rd_ptr != $past(q.rd_ptr)))
      else $error("data read did not remove a character");

   a_port_pins_forced: assert property ( // [RULE4]
      q.serial_port_enable |=> q.pins.tx_oe && !q.pins.rx_oe)
      else $error("port enable did not force pin directions");

   a_framing_error_status_stored_top: assert property ( // [RULE7]
      (push && q.cnt == 2'h0 && !pop)
      |=> q.fifo[q.rd_ptr].framing_error_status == $past(~maj))
      else $error("frame error not stored with character");

endmodule

// File: sim/asr_remote_tx.sv
`timescale 1ns/1ns
// ****************************************
// remote transmitter on the receive line
// ****************************************
module asr_remote_tx
(
   // clock and sixteen-times tick
   input  wire logic i_ref_clk,
   input  wire logic i_tick,
   // serial line, idles at mark
   output logic      o_line
);
   // the line reaches the receiver as a plain digital level
   initial o_line = 1'b1;

   // counts ticks with a bounded wait so a dead tick cannot hang the run
   task automatic ticks(input int n);
      repeat (n)
      begin
         @(posedge i_ref_clk);
         for (int k = 0; k < 8 && !i_tick; k++)
            @(posedge i_ref_clk);
      end
   endtask

   task automatic send(input logic [8:0] d, input int nb, input logic stp);
      o_line <= 1'b0;
      ticks(16);
      for (int i = 0; i < nb; i++)
      begin
         o_line <= d[i];
         ticks(16);
      end
      o_line <= stp;
      ticks(16);
      o_line <= 1'b1;
      ticks(16);
   endtask

   // low for a quarter bit only, so the half-bit check sees mark
   task automatic glitch();
      o_line <= 1'b0;
      ticks(4);
      o_line <= 1'b1;
      ticks(32);
   endtask
endmodule

// File: sim/asr_tb.sv
`timescale 1ns/1ns
module tb
   import asr_pkg::*;
;
   logic         i_ref_clk     = 1'b0;
   logic         i_reset       = 1'b1;
   logic         i_sample_tick = 1'b0;
   logic         i_rx_dir_in   = 1'b0;
   logic         i_tx_dir_in   = 1'b1;
   logic         i_tx_latch    = 1'b0;
   logic         i_tx_serial   = 1'b1;
   asr_bus_req_s i_bus         = '0;
   logic [7:0]   o_rdata;
   logic [15:0]  o_baud_div;
   logic         o_high_rate;
   logic         o_wide_div;
   logic         o_rx_ready;
   logic         o_irq;
   asr_pins_s    o_pins;
   logic         line;
   logic [1:0]   tcnt          = 2'h0;
   logic [7:0]   rv;
   int           error_cnt     = 0;
   int           cmp_count     = 0;

   always #10 i_ref_clk = ~i_ref_clk;

   // tick every fourth cycle keeps a frame near 700 cycles
   always @(posedge i_ref_clk)
   begin
      tcnt          <= tcnt + 2'h1;
      i_sample_tick <= (tcnt == 2'h3);
   end

   asr_receiver dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
      .i_sample_tick(i_sample_tick), .i_rx_pin(line),
      .i_rx_dir_in(i_rx_dir_in), .i_tx_dir_in(i_tx_dir_in),
      .i_tx_latch(i_tx_latch), .i_tx_serial(i_tx_serial), .i_bus(i_bus),
      .o_rdata(o_rdata), .o_baud_div(o_baud_div),
      .o_high_rate(o_high_rate), .o_wide_div(o_wide_div),
      .o_rx_ready(o_rx_ready), .o_irq(o_irq), .o_pins(o_pins));

   asr_remote_tx rtx (.i_ref_clk(i_ref_clk), .i_tick(i_sample_tick),
      .o_line(line));

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic close_out();
      if (error_cnt == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      cmp_count++;
      if (s !== e)
      begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge i_ref_clk);
      @(negedge i_ref_clk);
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge i_ref_clk);
      i_bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge i_ref_clk);
      i_bus <= '0;
   endtask

   task automatic rd(input logic [2:0] a);
      @(posedge i_ref_clk);
      i_bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge i_ref_clk);
      i_bus <= '0;
      @(negedge i_ref_clk);
      rv = o_rdata;
   endtask

   task automatic rchk(input logic [2:0] a, input logic [7:0] e);
      rd(a);
      chk(16'(rv), 16'(e));
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_regs();
      chk(16'(o_pins), 16'h4);
      rchk(3'h7, 8'h00);
      wr(ADDR_DIV_LO, 8'h34);
      wr(ADDR_DIV_HI, 8'h12);
      wr(ADDR_BAUD_CTL, 8'hff);
      wr(ADDR_XMT_STAT, 8'h04);
      rchk(ADDR_BAUD_CTL, 8'h5b);
      chk(o_baud_div, 16'h1234);
      chk(16'({o_wide_div, o_high_rate}), 16'h3);
      wr(ADDR_XMT_STAT, 8'h00);
      wr(ADDR_RCV_STAT, 8'h80);
      i_tx_serial <= 1'b0;
      cyc(2);
      chk(16'(o_pins), 16'h1);
      i_tx_serial <= 1'b1;
   endtask

   task automatic t_basic();
      wr(ADDR_RCV_STAT, 8'h90);
      wr(ADDR_INT_CTL, 8'h0b);
      rchk(ADDR_INT_CTL, 8'h03);
      rtx.send(9'h01e, 8, 1'b1);
      chk(16'(o_rx_ready), 16'h1);
      chk(16'(o_irq), 16'h0);
      wr(ADDR_INT_CTL, 8'h07);
      cyc(2);
      chk(16'(o_irq), 16'h1);
      rchk(ADDR_RCV_DATA, 8'h1e);
      cyc(3);
      chk(16'({o_rx_ready, o_irq}), 16'h0);
      wr(ADDR_INT_CTL, 8'h00);
   endtask

   task automatic t_glitch_sync();
      rtx.glitch();
      rtx.send(9'h0c4, 8, 1'b1);
      rchk(ADDR_RCV_DATA, 8'hc4);
      wr(ADDR_XMT_STAT, 8'h10);
      rtx.send(9'h055, 8, 1'b1);
      chk(16'(o_rx_ready), 16'h0);
      wr(ADDR_XMT_STAT, 8'h00);
   endtask

   task automatic t_framing_error_status();
      rtx.send(9'h0f0, 8, 1'b0);
      rtx.send(9'h00f, 8, 1'b1);
      rd(ADDR_RCV_STAT);
      chk(16'(rv[7:1]), 16'h4a);
      wr(ADDR_RCV_STAT, 8'h80);
      rd(ADDR_RCV_STAT);
      chk(16'(rv[7:1]), 16'h42);
      chk(16'(o_rx_ready), 16'h0);
      wr(ADDR_RCV_STAT, 8'h90);
      rchk(ADDR_RCV_DATA, 8'hf0);
      rd(ADDR_RCV_STAT);
      chk(16'(rv[7:1]), 16'h48);
      rchk(ADDR_RCV_DATA, 8'h0f);
   endtask

   task automatic t_overrun();
      rtx.send(9'h011, 8, 1'b1);
      rtx.send(9'h022, 8, 1'b1);
      rtx.send(9'h033, 8, 1'b1);
      rd(ADDR_RCV_STAT);
      chk(16'(rv[1]), 16'h1);
      rchk(ADDR_RCV_DATA, 8'h11);
      rchk(ADDR_RCV_DATA, 8'h22);
      rtx.send(9'h044, 8, 1'b1);
      chk(16'(o_rx_ready), 16'h0);
      wr(ADDR_RCV_STAT, 8'h80);
      wr(ADDR_RCV_STAT, 8'h90);
      rd(ADDR_RCV_STAT);
      chk(16'(rv[1]), 16'h0);
      rtx.send(9'h055, 8, 1'b1);
      rchk(ADDR_RCV_DATA, 8'h55);
   endtask

   task automatic t_addr();
      wr(ADDR_RCV_STAT, 8'h00);
      wr(ADDR_RCV_STAT, 8'hc0);
      wr(ADDR_RCV_STAT, 8'hc8);
      wr(ADDR_RCV_STAT, 8'hd8);
      rtx.send(9'h066, 9, 1'b1);
      chk(16'(o_rx_ready), 16'h0);
      rtx.send(9'h1a7, 9, 1'b1);
      rd(ADDR_RCV_STAT);
      chk(16'(rv[0]), 16'h1);
      rchk(ADDR_RCV_DATA, 8'ha7);
      wr(ADDR_RCV_STAT, 8'hd0);
      rtx.send(9'h0b8, 9, 1'b1);
      rd(ADDR_RCV_STAT);
      chk(16'(rv[0]), 16'h0);
      rchk(ADDR_RCV_DATA, 8'hb8);
   endtask

   initial
   begin
      #1000000;
      error_cnt++;
      close_out();
   end

   initial
   begin
      repeat (6) @(posedge i_ref_clk);
      i_reset <= 1'b0;
      cyc(2);
      t_regs();
      t_basic();
      t_glitch_sync();
      t_framing_error_status();
      t_overrun();
      t_addr();
      close_out();
   end
endmodule
